// ==== logic/zq_term_ctrl.sv ====
// Purpose: Impedance calibration sequencing and termination selection
// Assumes: Commands arrive decoded on aclk; the control pin is asynchronous
// Notes:   Registers over AXI4-Lite; windows are module parameters
//
// How it works
// - First long cal gets initial window, later operational
// - Long cal runs engine then updates I/O
// - Short cal finishes in short window
// - No calibration after self-refresh exit unless commanded
// - Pin low during cal, device holds park
// - Calibration current path off when done
// - Self refresh forces high impedance termination
// - Pin ignored if nominal zero or self refresh
// - Termination off when all fields zero
// - Five termination states selected
// - Write termination regardless of pin level
// - Nominal termination on when pin sampled high
// - Park value when pin low and enabled
// - Read disables termination RL-X for BL/2+X+Y
// - Priority read, write, nominal, park
// - Nominal follows pin after WL minus X
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "zq_term_defines.svh"
module zq_term_ctrl
    import zq_term_pkg::*;
#(
    parameter int INIT_CAL  = `INIT_CAL_CYCLES,   // initial_cal_window
    parameter int OPER_CAL  = `OPER_CAL_CYCLES,   // operational_cal_window
    parameter int SHORT_CAL = `SHORT_CAL_CYCLES   // short_cal_window
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         awvalid,
    output      logic         awready,
    input  wire logic [7:0]   awaddr,
    input  wire logic         wvalid,
    output      logic         wready,
    input  wire logic [31:0]  wdata,
    input  wire logic [3:0]   wstrb,
    output      logic         bvalid,
    input  wire logic         bready,
    output      logic [1:0]   bresp,
    input  wire logic         arvalid,
    output      logic         arready,
    input  wire logic [7:0]   araddr,
    output      logic         rvalid,
    input  wire logic         rready,
    output      logic [31:0]  rdata,
    output      logic [1:0]   rresp,
    input  wire cmd_kind_type command,
    input  wire logic         termination_control_pin,
    output      term_out_type term_out,
    output      logic         cal_busy,
    output      logic         cal_engine_on,
    output      logic         cal_io_update
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic          aw_got;     // Write address held
        logic [7:0]    aw_addr;
        logic          w_got;      // Write data held
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
        logic [2:0]    nom;        // mode_register_one nominal field
        logic [1:0]    wrt;        // mode_register_two write field
        logic [2:0]    park;       // mode_register_five park field
        logic [5:0]    wl;         // Write latency
        logic [5:0]    rl;         // Read latency
        logic          pre2;       // Two-cycle preamble
        logic          crc;        // Write CRC enabled
        logic          bl8;        // Burst of eight
        logic          pin_s1;     // Synchroniser first stage
        logic          pin_s2;     // Synchroniser second stage
        logic [63:0]   hist;       // Sampled pin history
        cal_state_type cal;
        logic [15:0]   cal_cnt;
        logic          first_done; // First long cal has completed
        logic          engine_on;
        logic          io_update;
        logic          self_ref;
        logic [6:0]    rd_wait;
        logic [4:0]    rd_left;
        logic [6:0]    wr_wait;
        logic [4:0]    wr_left;
        term_out_type  term;
    } state_type;

    state_type s;        // Registered state
    state_type next_s;   // Next state
    logic [6:0] x_val;   // Preamble-dependent offset
    logic [4:0] burst;   // BL/2 + X + Y
    logic [6:0] nom_lat; // WL - X
    logic       nom_req; // Delayed pin after latency
    logic       wr_hit;  // Write address and data both held

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Timing terms
    // ------------------------------------------------------------------
    always_comb begin
        x_val   = s.pre2 ? `X_TWO_PRE : `X_ONE_PRE;
        burst   = (s.bl8 ? `HALF_BL8 : `HALF_BC4) + 5'(x_val) + {4'h0, s.crc};
        // Saturate so a tiny latency does not wrap
        nom_lat = ({1'b0, s.wl} > x_val) ? {1'b0, s.wl} - x_val : 7'h00;
        nom_req = (nom_lat == 7'h00) ? s.pin_s2 : s.hist[6'(nom_lat - 7'h01)];
        wr_hit  = s.aw_got && s.w_got;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] lat_word;
        lat_word = {13'h0, s.bl8, s.crc, s.pre2, 2'h0, s.rl, 2'h0, s.wl};
        next_s = s;
        next_s.io_update = 1'b0;
        // Pin synchroniser and history; first stage feeds only the second
        next_s.pin_s1 = termination_control_pin;
        next_s.pin_s2 = s.pin_s1;
        next_s.hist   = {s.hist[62:0], s.pin_s2};
        // AXI write channel: address and data in either order
        if (awvalid && !s.aw_got && !s.bvalid) begin
            next_s.aw_got  = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && !s.w_got && !s.bvalid) begin
            next_s.w_got  = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (wr_hit) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = `AXI_OKAY;
            unique case (s.aw_addr)
                `OFS_MODE_ONE:  next_s.nom  = 3'(merge(32'(s.nom), s.w_data, s.w_strb));
                `OFS_MODE_TWO:  next_s.wrt  = 2'(merge(32'(s.wrt), s.w_data, s.w_strb));
                `OFS_MODE_FIVE: next_s.park = 3'(merge(32'(s.park), s.w_data, s.w_strb));
                `OFS_LATENCY: begin
                    lat_word    = merge(lat_word, s.w_data, s.w_strb);
                    next_s.wl   = lat_word[`LAT_WL_LSB +: 6];
                    next_s.rl   = lat_word[`LAT_RL_LSB +: 6];
                    next_s.pre2 = lat_word[`LAT_PRE2_BIT];
                    next_s.crc  = lat_word[`LAT_CRC_BIT];
                    next_s.bl8  = lat_word[`LAT_BL8_BIT];
                end
                `OFS_STATUS:    ;                      // Read-only, write ignored
                default:        next_s.bresp = `AXI_SLVERR;
            endcase
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        // AXI read channel
        if (arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `AXI_OKAY;
            unique case (araddr)
                `OFS_MODE_ONE:  next_s.rdata = 32'(s.nom);
                `OFS_MODE_TWO:  next_s.rdata = 32'(s.wrt);
                `OFS_MODE_FIVE: next_s.rdata = 32'(s.park);
                `OFS_LATENCY:   next_s.rdata = lat_word;
                `OFS_STATUS:    next_s.rdata = {21'h0, s.term.state, s.self_ref,
                                                s.engine_on, s.first_done, s.cal != CAL_IDLE,
                                                1'b0, 1'b0};
                default: begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = `AXI_SLVERR;
                end
            endcase
        end else if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        // Calibration sequencer; only an explicit command starts it
        unique case (s.cal)
            CAL_IDLE: begin
                if (command == CMD_LONG_CAL && !s.self_ref) begin
                    next_s.cal       = CAL_LONG;
                    next_s.engine_on = 1'b1;
                    next_s.cal_cnt   = s.first_done ? 16'(OPER_CAL - 1)
                                                    : 16'(INIT_CAL - 1);
                end else if (command == CMD_SHORT_CAL && !s.self_ref) begin
                    next_s.cal       = CAL_SHORT;
                    next_s.engine_on = 1'b1;
                    next_s.cal_cnt   = 16'(SHORT_CAL - 1);
                end
            end
            CAL_LONG, CAL_SHORT: begin
                if (s.cal_cnt == 16'h0) begin
                    // Results move to the I/O in the same cycle the current path shuts off
                    next_s.cal        = CAL_IDLE;
                    next_s.io_update  = 1'b1;
                    next_s.engine_on  = 1'b0;
                    next_s.first_done = s.first_done || (s.cal == CAL_LONG);
                end else begin
                    next_s.cal_cnt = s.cal_cnt - 16'h1;
                end
            end
            default: next_s.cal = CAL_IDLE;
        endcase
        // Self refresh entry and exit
        if (command == CMD_SRE) begin
            next_s.self_ref = 1'b1;
        end else if (command == CMD_SRX) begin
            next_s.self_ref = 1'b0;
        end
        // Read-time disable window: wait RL-X, then hold BL/2+X+Y
        if (s.rd_left != 5'h0) begin
            next_s.rd_left = s.rd_left - 5'h1;
        end
        if (s.rd_wait != 7'h0) begin
            next_s.rd_wait = s.rd_wait - 7'h1;
            if (s.rd_wait == 7'h1) begin
                next_s.rd_left = burst;
            end
        end
        if (command == CMD_RD) begin
            if ({1'b0, s.rl} > x_val) begin
                next_s.rd_wait = {1'b0, s.rl} - x_val;
            end else begin
                next_s.rd_left = burst;
            end
        end
        // Write termination window, same shape on the write latency
        if (s.wr_left != 5'h0) begin
            next_s.wr_left = s.wr_left - 5'h1;
        end
        if (s.wr_wait != 7'h0) begin
            next_s.wr_wait = s.wr_wait - 7'h1;
            if (s.wr_wait == 7'h1) begin
                next_s.wr_left = burst;
            end
        end
        if (command == CMD_WR) begin
            if (nom_lat != 7'h0) begin
                next_s.wr_wait = nom_lat;
            end else begin
                next_s.wr_left = burst;
            end
        end
        // Termination selection, highest priority first
        if (s.self_ref) begin
            next_s.term = '{TERM_HIZ, 3'h0};
        end else if (s.cal != CAL_IDLE) begin
            // Pin is held low by the far side; park stays on
            next_s.term = (s.park != 3'h0) ? term_out_type'{TERM_PARK, s.park}
                                           : term_out_type'{TERM_HIZ, 3'h0};
        end else if (s.rd_left != 5'h0) begin
            next_s.term = '{TERM_RD_OFF, 3'h0};
        end else if (s.wr_left != 5'h0 && s.wrt != 2'h0) begin
            next_s.term = '{TERM_WR, {1'b0, s.wrt}};
        end else if (s.nom != 3'h0 && nom_req) begin
            next_s.term = '{TERM_NOM, s.nom};
        end else if (s.park != 3'h0) begin
            next_s.term = '{TERM_PARK, s.park};
        end else begin
            next_s.term = '{TERM_HIZ, 3'h0};
        end
    end

    // ------------------------------------------------------------------
    // State register, synchronous reset
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s      <= '0;
            s.nom  <= `RST_NOM;
            s.wrt  <= `RST_WRT;
            s.park <= `RST_PARK;
            s.wl   <= `RST_WL;
            s.rl   <= `RST_RL;
            s.cal  <= CAL_IDLE;
            s.term <= '{TERM_HIZ, 3'h0};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign awready       = !s.aw_got && !s.bvalid;
    assign wready        = !s.w_got && !s.bvalid;
    assign bvalid        = s.bvalid;
    assign bresp         = s.bresp;
    assign arready       = !s.rvalid;
    assign rvalid        = s.rvalid;
    assign rdata         = s.rdata;
    assign rresp         = s.rresp;
    assign term_out      = s.term;
    assign cal_busy      = (s.cal != CAL_IDLE);
    assign cal_engine_on = s.engine_on;
    assign cal_io_update = s.io_update;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [15:0] busy_len;   // Cycles spent in the current window
    logic [15:0] want_len;   // Window length expected for it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_len <= 16'h0;
            want_len <= 16'h0;
        end else if (s.cal == CAL_IDLE) begin
            busy_len <= 16'h0;
            // Expected long window from the parameters, not from the counter
            want_len <= s.first_done ? 16'(OPER_CAL) : 16'(INIT_CAL);
        end else begin
            busy_len <= busy_len + 16'h1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    long_window_len_a: assert property ($fell(s.cal == CAL_LONG)
                                        |-> busy_len == want_len)
        else $error("long calibration window length wrong");
    short_window_len_a: assert property ($fell(s.cal == CAL_SHORT)
                                         |-> busy_len == 16'(SHORT_CAL))
        else $error("short calibration window length wrong");
    io_transfer_a: assert property ($fell(cal_busy)
                                    |-> cal_io_update && !cal_engine_on)
        else $error("calibration end without I/O update");
    no_self_cal_a: assert property ($rose(cal_busy)
                                    |-> $past(command inside {CMD_LONG_CAL, CMD_SHORT_CAL}))
        else $error("calibration started without command");
    engine_idle_off_a: assert property (!cal_busy |-> !cal_engine_on)
        else $error("calibration current left on");
    sref_hiz_a: assert property ($past(s.self_ref) |-> term_out.state == TERM_HIZ)
        else $error("termination active in self refresh");
    cal_park_a: assert property ($past(cal_busy && !s.self_ref && s.park != 3'h0)
                                 |-> term_out == term_out_type'{TERM_PARK, $past(s.park)})
        else $error("park not held during calibration");
    nom_ignored_a: assert property ($past(s.nom) == 3'h0
                                    |-> term_out.state != TERM_NOM)
        else $error("nominal applied while disabled");
    all_zero_hiz_a: assert property ($past(s.nom == 3'h0 && s.wrt == 2'h0
                                           && s.park == 3'h0)
                                     |-> term_out.state inside {TERM_HIZ, TERM_RD_OFF})
        else $error("termination on with all fields zero");
    read_first_a: assert property ($past(s.rd_left != 5'h0 && !s.self_ref
                                         && !cal_busy)
                                   |-> term_out.state == TERM_RD_OFF)
        else $error("read disable lost priority");
    read_len_a: assert property ($rose(s.rd_left != 5'h0) |-> s.rd_left == burst)
        else $error("read disable length wrong");
    write_term_a: assert property ($past(s.wr_left != 5'h0 && s.rd_left == 5'h0
                                         && s.wrt != 2'h0 && !s.self_ref && !cal_busy)
                                   |-> term_out.state == TERM_WR)
        else $error("write termination missing");
    nom_on_a: assert property ($past(nom_req && s.nom != 3'h0 && s.wr_left == 5'h0
                                     && s.rd_left == 5'h0 && !s.self_ref && !cal_busy)
                              |-> term_out.state == TERM_NOM)
        else $error("nominal termination missing");
    park_default_a: assert property ($past(!nom_req && s.park != 3'h0
                                           && s.wr_left == 5'h0 && s.rd_left == 5'h0
                                           && !s.self_ref)
                                    |-> term_out.state == TERM_PARK)
        else $error("park default missing");

    long_cal_c: cover property ($fell(s.cal == CAL_LONG));
    short_cal_c: cover property ($fell(s.cal == CAL_SHORT));
    read_off_c: cover property (term_out.state == TERM_RD_OFF);
    nominal_on_c: cover property (term_out.state == TERM_NOM);
endmodule

// ==== logic/zq_term_defines.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit register words at aligned byte addresses
// Notes:   Definitions only
`ifndef ZQ_TERM_DEFINES_SVH
`define ZQ_TERM_DEFINES_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_MODE_ONE      8'h00
`define OFS_MODE_TWO      8'h04
`define OFS_MODE_FIVE     8'h08
`define OFS_LATENCY       8'h0C
`define OFS_STATUS        8'h10
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NOM_LSB           0
`define WRT_LSB           0
`define PARK_LSB          0
`define LAT_WL_LSB        0
`define LAT_RL_LSB        8
`define LAT_PRE2_BIT      16
`define LAT_CRC_BIT       17
`define LAT_BL8_BIT       18
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_NOM           3'h0
`define RST_WRT           2'h0
`define RST_PARK          3'h0
`define RST_WL            6'h09
`define RST_RL            6'h0B
// ----------------------------------------------------------------------
// Timing counts in clock cycles, then AXI response codes
// ----------------------------------------------------------------------
`define INIT_CAL_CYCLES   1024
`define OPER_CAL_CYCLES   512
`define SHORT_CAL_CYCLES  128
`define X_ONE_PRE         7'h02
`define X_TWO_PRE         7'h03
`define HALF_BL8          5'h04
`define HALF_BC4          5'h02
`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2
`endif

// ==== logic/zq_term_pkg.sv ====
// Purpose: Types shared by the calibration and termination block
// Assumes: One-hot codes throughout
// Notes:   Constants live in the defines header
package zq_term_pkg;
    // Decoded command from the command decoder, one-hot
    typedef enum logic [6:0] {
        CMD_NOP       = 7'h01,
        CMD_LONG_CAL  = 7'h02,   // long_impedance_cal_cmd
        CMD_SHORT_CAL = 7'h04,   // short_impedance_cal_cmd
        CMD_RD        = 7'h08,
        CMD_WR        = 7'h10,
        CMD_SRE       = 7'h20,
        CMD_SRX       = 7'h40
    } cmd_kind_type;
    // Calibration sequencer
    typedef enum logic [2:0] {
        CAL_IDLE  = 3'h1,
        CAL_LONG  = 3'h2,
        CAL_SHORT = 3'h4
    } cal_state_type;
    // Termination state presented at the data pins
    typedef enum logic [4:0] {
        TERM_HIZ    = 5'h01,
        TERM_RD_OFF = 5'h02,
        TERM_WR     = 5'h04,
        TERM_NOM    = 5'h08,
        TERM_PARK   = 5'h10
    } term_state_type;
    // Termination drive to the I/O
    typedef struct packed {
        term_state_type state;
        logic [2:0]     value;
    } term_out_type;
endpackage

// ==== tb/ctrl_model.sv ====
// Purpose: Controller side: commands and the termination pin
// Assumes: Changes just after the rising edge
// Notes:   Bench calls its tasks
`timescale 1ns/100ps
module ctrl_model
    import zq_term_pkg::*;
(
    input  wire logic   aclk,
    output cmd_kind_type command,
    output logic         pin
);
    // Quiet idle channel, pin low
    initial command = CMD_NOP;
    initial pin = 1'b0;
    // One command a cycle, pin low for cal
    task automatic issue(input cmd_kind_type c);
        @(posedge aclk);
        command <= c;
        if (c inside {CMD_LONG_CAL, CMD_SHORT_CAL}) pin <= 1'b0;
        @(posedge aclk);
        command <= CMD_NOP;
    endtask
    // Pin moves only off the edge
    task automatic drive_pin(input logic v);
        @(posedge aclk);
        pin <= v;
    endtask
endmodule

// ==== tb/zq_term_ctrl_tb.sv ====
// Purpose: Self-checking bench for calibration and termination
// Assumes: Windows shortened through parameters
// Notes:   Register model is an int array
`timescale 1ns/100ps
`include "zq_term_defines.svh"
module zq_term_ctrl_tb
    import zq_term_pkg::*;
;
    localparam int INIT_W = 20, OPER_W = 10, SHORT_W = 8;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, pin;
    logic cal_busy, cal_engine_on, cal_io_update;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] p, n;
    cmd_kind_type command;
    term_out_type term_out;
    int fail_count = 0, num_checks = 0, cycles = 0;
    int mreg[4] = '{0, 0, 0, 32'h0B09};    // Model, reset values
    int mask[4] = '{7, 3, 7, 32'h73F3F};   // Writable bits
    ctrl_model i_ctrl (.aclk, .command, .pin);
    zq_term_ctrl #(.INIT_CAL(INIT_W), .OPER_CAL(OPER_W), .SHORT_CAL(SHORT_W)) i_dut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hF),
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
        .rresp, .command, .termination_control_pin(pin), .term_out, .cal_busy,
        .cal_engine_on, .cal_io_update);
    initial forever #2.5 aclk = ~aclk;
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= v;
        bready <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            pa = pa && !awready;
            pw = pw && !wready;
            awvalid <= pa;
            wvalid <= pw;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("write resp", a < 8'h10 ? `AXI_OKAY : `AXI_SLVERR, bresp);
        if (a < 8'h10) mreg[a[3:2]] = v & mask[a[3:2]];
    endtask
    task automatic rdchk(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("read data", a < 8'h10 ? mreg[a[3:2]] : 0, rdata);
        chk("read resp", a < 8'h10 ? `AXI_OKAY : `AXI_SLVERR, rresp);
    endtask
    // Busy and engine cycles summed, one update pulse per window
    task automatic cal(input cmd_kind_type c, input int w);
        logic [31:0] nb, nu;
        nb = 0;
        nu = 0;
        i_ctrl.issue(c);
        repeat (30) begin
            @(posedge aclk);
            nb += cal_busy + cal_engine_on;
            nu += cal_io_update;
        end
        chk("cal cycles", 2 * w, nb);
        chk("io updates", w > 0, nu);
    endtask
    task automatic win(input cmd_kind_type c, input term_state_type s, input int w);
        logic [31:0] cnt;
        cnt = 0;
        i_ctrl.issue(c);
        repeat (40) begin
            @(posedge aclk);
            cnt += (term_out.state === s);
        end
        chk("term window", w, cnt);
    endtask
    task automatic tchk(input term_state_type s, input logic [2:0] v);
        repeat (16) @(posedge aclk);
        chk("term state", {s, v}, term_out);
    endtask
    // Hang guard, well above the planned run
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            test_done;
        end
    end
    initial begin
        void'($urandom(32'h9B169BC5));
        p = 3'($urandom_range(7, 1));
        n = 3'($urandom_range(7, 1));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdchk(8'(4 * i));
            wr(8'(4 * i), $urandom);
            rdchk(8'(4 * i));
        end
        wr(8'h14, $urandom);
        rdchk(8'h14);
        // Known fields and latency first, so park is on during the windows
        wr(`OFS_MODE_FIVE, p);
        wr(`OFS_MODE_ONE, n);
        wr(`OFS_MODE_TWO, 2);
        wr(`OFS_LATENCY, 32'h0000_0B09);
        cal(CMD_LONG_CAL, INIT_W);
        cal(CMD_LONG_CAL, OPER_W);
        cal(CMD_SHORT_CAL, SHORT_W);
        tchk(TERM_PARK, p);
        i_ctrl.drive_pin(1'b1);
        tchk(TERM_NOM, n);
        for (int k = 0; k < 2; k++) begin
            wr(`OFS_LATENCY, k ? 32'h0007_0B09 : 32'h0000_0B09);
            win(CMD_RD, TERM_RD_OFF, (k ? 4 : 2) + (k ? 3 : 2) + k);
            win(CMD_WR, TERM_WR, (k ? 4 : 2) + (k ? 3 : 2) + k);
        end
        i_ctrl.issue(CMD_SRE);
        tchk(TERM_HIZ, 3'h0);
        cal(CMD_SHORT_CAL, 0);
        i_ctrl.issue(CMD_SRX);
        cal(CMD_NOP, 0);
        wr(`OFS_MODE_ONE, 0);
        i_ctrl.drive_pin(1'b1);
        tchk(TERM_PARK, p);
        // Second reset: the next long window is the initial one again
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        cal(CMD_LONG_CAL, INIT_W);
        test_done;
    end
endmodule
